// >>> logic/mrd_lane_regs.vh
// Constants for the receive lane: register offsets, field positions, reset values, timing.
// Assumes a 25 MHz system clock and a 32-bit Avalon-MM register port with byte addresses.
`ifndef MRD_LANE_REGS_VH
`define MRD_LANE_REGS_VH

// Register byte offsets
`define MRD_OFS_CTRL 4'h0
`define MRD_OFS_STATUS 4'h4
`define MRD_OFS_DATA 4'h8
`define MRD_OFS_LPIN 4'hc

// Control register fields
`define MRD_CTRL_HS_MODE 0
`define MRD_CTRL_FIFO_EN 1
`define MRD_CTRL_LANE_RST 2
`define MRD_CTRL_RESET 3'h3

// Status register fields
`define MRD_ST_EMPTY 0
`define MRD_ST_OVERFLOW 1
`define MRD_ST_TAP_LSB 8
`define MRD_ST_CNT_LSB 16

// Low-power input register fields
`define MRD_LP_POS 0
`define MRD_LP_NEG 1

// Deserializer
`define MRD_DESER_FACTOR 4'h8
`define MRD_BITCNT_LAST 3'h7
`define MRD_CORE_DIV_PHASE 1'h1
`define MRD_PAR_DIV_PHASE 2'h3

// Line rate limit of a lane, in Mbit/s
`define MRD_LINE_RATE_MBPS 1500

// Reset values
`define MRD_ZERO_WORD 8'h00
`define MRD_ZERO_BUS 32'h0000_0000

`endif

// >>> logic/mrd_lane.v
// One receive lane group slice: clock-lane recovery, one data lane deserializer,
// low-power pass-through, dynamic input delay and an optional crossing buffer.
// Assumes pad levels arrive asynchronously; the serial clock arrives on a pad and is
// sampled here, so only line rates well below the system clock are really captured.
`timescale 1ns/10ps
`default_nettype none
`include "mrd_lane_regs.vh"

// How it works
// R01: HS mode shifts eight serial bits per word
// R02: LP mode passes pad levels, no shifting
// R03: Lanes rated up to 1.5 Gbps; here the 25 MHz clk samples the serial clock, so only far lower rates
// R04: One clock lane plus 1/2/4/8 data lanes; this slice has one data lane only
// R05: Clock lane divides serial clock, forwards both
// R06: Data lane clocked only from own clock lane
// R07: One clock lane per channel, eighteen channels; this module is a single channel
// R08: Extra clock output at serial divided by four
// R09: Core runs from the divided clock
// R10: Received word is eight bits, parallel clock
// R11: Empty flag high while buffer holds nothing
// R12: Core read enable takes one word per cycle
// R13: Lane reset clears buffer and deserializer
// R14: Delay enable steps tap up or down
// R15: Delay clear returns tap to initial value
// R16: Positive and negative pad levels reported separately
// R17: Each pad driven while its enable set
// R18: HS input buffer enabled by core signal
// R19: HS termination switched by core signal
// R20: Forwarded clocks feed only data lanes
// R21: Core never reads while buffer empty
module mrd_lane #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3,
  parameter DELAY_TAPS = 16,
  parameter TAP_W = 4,
  parameter [TAP_W-1:0] TAP_INIT = 4'h0
) (
  input wire clk, // System clock, 25 MHz
  input wire sys_rst, // Synchronous reset, active high
  input wire [3:0] avs_address, // Avalon byte address
  input wire avs_read, // Avalon read
  input wire avs_write, // Avalon write
  input wire [31:0] avs_writedata, // Avalon write data
  input wire [3:0] avs_byteenable, // Avalon byte enables
  output reg [31:0] avs_readdata, // Avalon read data
  output wire avs_waitrequest, // Avalon wait request
  input wire clk_pad_in, // Clock lane pad, serial clock
  input wire pad_pos_in, // Data lane positive pad level
  input wire pad_neg_in, // Data lane negative pad level
  output reg pad_pos_out, // Positive pad drive value
  output reg pad_pos_oe, // Positive pad drive enable
  output reg pad_neg_out, // Negative pad drive value
  output reg pad_neg_oe, // Negative pad drive enable
  input wire lowpower_pos_out_enable, // Core enable for positive pad
  input wire lowpower_pos_out_data, // Core data for positive pad
  input wire lowpower_neg_out_enable, // Core enable for negative pad
  input wire lowpower_neg_out_data, // Core data for negative pad
  output reg lowpower_pos_in_data, // Positive pad level to core
  output reg lowpower_neg_in_data, // Negative pad level to core
  input wire highspeed_buffer_enable, // Differential buffer enable
  input wire highspeed_termination_enable, // Termination request
  output reg termination_on, // Termination switch to pad
  output reg forwarded_serial_clock, // Serial clock to data lanes
  output reg forwarded_parallel_clock, // Parallel clock to data lanes
  output reg divided_core_clock, // Serial clock divided by four
  output reg [7:0] highspeed_rx_word, // Received word
  output reg word_valid, // One-cycle pulse with new word
  output wire fifo_empty, // Buffer empty flag
  input wire fifo_read_enable, // Core read strobe
  input wire lane_reset, // Lane reset from core
  input wire delay_step_enable, // Delay step enable
  input wire delay_step_direction, // 1 steps up, 0 steps down
  input wire delay_counter_clear // Delay back to initial tap
);

  reg [2:0] ctrl;
  reg overflow;
  reg ack;
  reg clk_s1, clk_s2, clk_s3;
  reg pos_s1, pos_s2;
  reg neg_s1, neg_s2;
  reg [DELAY_TAPS-1:0] hist;
  reg [TAP_W-1:0] tap;
  reg [7:0] shifter;
  reg [2:0] bitcnt;
  reg word_strobe;
  reg [7:0] last_word;
  reg [7:0] mem [0:FIFO_DEPTH-1];
  reg [FIFO_AW-1:0] wr_ptr, rd_ptr;
  reg [FIFO_AW:0] count;
  wire hs_mode = ctrl[`MRD_CTRL_HS_MODE];
  wire fifo_en = ctrl[`MRD_CTRL_FIFO_EN];
  // Software bit and system reset clear the lane on an edge; the pin clears it at once
  wire lane_clear = sys_rst | ctrl[`MRD_CTRL_LANE_RST];
  wire bus_req = avs_read | avs_write;
  wire taken = bus_req & ack;
  // Pad clock idles low and clk_s3 resets low, so no false edge follows reset
  wire serial_edge = clk_s2 & ~clk_s3; // R04 R07
  wire diff_bit = hist[tap];
  wire shift_en = hs_mode & highspeed_buffer_enable & serial_edge;
  wire word_done = shift_en & (bitcnt == `MRD_BITCNT_LAST);
  wire [7:0] next_word = {diff_bit, shifter[7:1]};
  // Full at FIFO_DEPTH words; a word that arrives then is lost
  wire fifo_full = (count == FIFO_DEPTH[FIFO_AW:0]);
  // Bus and core share one pop; software should not read DATA while the core reads
  wire bus_pop = taken & avs_read & (avs_address == `MRD_OFS_DATA);
  wire pop = fifo_en & ~fifo_empty & (fifo_read_enable | bus_pop); // R21
  wire push = fifo_en & word_done & ~fifo_full;
  // Overflow is write-one-to-clear through the low byte
  wire ovf_clear = taken & avs_write & (avs_address == `MRD_OFS_STATUS) &
                   avs_byteenable[0] & avs_writedata[`MRD_ST_OVERFLOW];

  // One wait cycle, then the answer
  assign avs_waitrequest = bus_req & ~ack;
  assign fifo_empty = (count == {(FIFO_AW+1){1'b0}}); // R11

  always @(posedge clk)
  begin
    if (sys_rst)
      ack <= 1'b0;
    else
      ack <= bus_req & ~ack;
  end

  // A write lands only on the answer edge, one edge after the wait cycle ends
  always @(posedge clk)
  begin
    if (sys_rst)
      ctrl <= `MRD_CTRL_RESET;
    else if (taken & avs_write & (avs_address == `MRD_OFS_CTRL) & avs_byteenable[0])
      ctrl <= avs_writedata[2:0];
  end

  // Read data loads in the wait cycle and stands at the answer edge
  always @(posedge clk)
  begin
    if (sys_rst)
      avs_readdata <= `MRD_ZERO_BUS;
    else if (avs_read & ~ack)
    begin
      avs_readdata <= `MRD_ZERO_BUS;
      case (avs_address)
        `MRD_OFS_CTRL:
          avs_readdata[2:0] <= ctrl;
        `MRD_OFS_STATUS:
        begin
          avs_readdata[`MRD_ST_EMPTY] <= fifo_empty;
          avs_readdata[`MRD_ST_OVERFLOW] <= overflow;
          avs_readdata[`MRD_ST_TAP_LSB +: TAP_W] <= tap;
          avs_readdata[`MRD_ST_CNT_LSB +: FIFO_AW+1] <= count;
        end
        `MRD_OFS_DATA:
          avs_readdata[7:0] <= fifo_en ? mem[rd_ptr] : last_word;
        `MRD_OFS_LPIN:
        begin
          avs_readdata[`MRD_LP_POS] <= lowpower_pos_in_data;
          avs_readdata[`MRD_LP_NEG] <= lowpower_neg_in_data;
        end
        default:
          avs_readdata <= `MRD_ZERO_BUS;
      endcase
    end
  end

  // Pad synchronisers; first stage feeds only the second
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      pos_s1 <= 1'b0;
      pos_s2 <= 1'b0;
      neg_s1 <= 1'b0;
      neg_s2 <= 1'b0;
    end
    else
    begin
      clk_s1 <= clk_pad_in;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      pos_s1 <= pad_pos_in;
      pos_s2 <= pos_s1;
      neg_s1 <= pad_neg_in;
      neg_s2 <= neg_s1;
    end
  end

  // Low-power path and pad control
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      lowpower_pos_in_data <= 1'b0;
      lowpower_neg_in_data <= 1'b0;
      pad_pos_out <= 1'b0;
      pad_pos_oe <= 1'b0;
      pad_neg_out <= 1'b0;
      pad_neg_oe <= 1'b0;
      termination_on <= 1'b0;
    end
    else
    begin
      lowpower_pos_in_data <= pos_s2; // R02 R16
      lowpower_neg_in_data <= neg_s2; // R02 R16
      pad_pos_out <= lowpower_pos_out_data; // R17
      pad_pos_oe <= lowpower_pos_out_enable; // R17
      pad_neg_out <= lowpower_neg_out_data; // R17
      pad_neg_oe <= lowpower_neg_out_enable; // R17
      termination_on <= hs_mode & highspeed_termination_enable; // R19
    end
  end

  // Delay line: history of differential samples, tap picks the age
  always @(posedge clk)
  begin
    if (sys_rst)
      hist <= {DELAY_TAPS{1'b0}};
    else if (highspeed_buffer_enable) // R18
      hist <= {hist[DELAY_TAPS-2:0], pos_s2 & ~neg_s2};
  end

  // Tap steps once per received word, the cycle after its last bit; saturates at both ends
  always @(posedge clk)
  begin
    if (sys_rst)
      tap <= TAP_INIT;
    // A clear beats a step in the same cycle
    else if (delay_counter_clear)
      tap <= TAP_INIT; // R15
    else if (delay_step_enable & word_strobe)
    begin
      if (delay_step_direction & (tap != DELAY_TAPS[TAP_W-1:0] - 1'b1))
        tap <= tap + 1'b1; // R14
      else if (~delay_step_direction & (tap != {TAP_W{1'b0}}))
        tap <= tap - 1'b1; // R14
    end
  end

  // Clock lane: serial edges clock the data lane and the dividers
  always @(posedge clk or posedge lane_reset)
  begin
    if (lane_reset)
    begin
      forwarded_serial_clock <= 1'b0; // R13
      forwarded_parallel_clock <= 1'b0;
      divided_core_clock <= 1'b0;
      bitcnt <= 3'h0;
    end
    else if (lane_clear)
    begin
      forwarded_serial_clock <= 1'b0;
      forwarded_parallel_clock <= 1'b0;
      divided_core_clock <= 1'b0;
      bitcnt <= 3'h0;
    end
    else
    begin
      forwarded_serial_clock <= clk_s2; // R05 R20
      if (shift_en) // R03 R06
      begin
        bitcnt <= bitcnt + 1'b1;
        if (bitcnt[0] == `MRD_CORE_DIV_PHASE)
          divided_core_clock <= ~divided_core_clock; // R08 R09
        if (bitcnt[1:0] == `MRD_PAR_DIV_PHASE)
          forwarded_parallel_clock <= ~forwarded_parallel_clock; // R05 R20
      end
    end
  end

  // Deserializer, first bit lands in bit 0
  always @(posedge clk or posedge lane_reset)
  begin
    if (lane_reset)
    begin
      shifter <= `MRD_ZERO_WORD; // R13
      last_word <= `MRD_ZERO_WORD;
      word_strobe <= 1'b0;
    end
    else if (lane_clear)
    begin
      shifter <= `MRD_ZERO_WORD;
      last_word <= `MRD_ZERO_WORD;
      word_strobe <= 1'b0;
    end
    else
    begin
      word_strobe <= word_done;
      if (shift_en)
        shifter <= next_word; // R01
      if (word_done)
        last_word <= next_word; // R01 R10
    end
  end

  // Crossing buffer
  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= next_word;
  end

  // Pointers; the pin clears them at once so a stuck core cannot hold stale words
  always @(posedge clk or posedge lane_reset)
  begin
    if (lane_reset)
    begin
      wr_ptr <= {FIFO_AW{1'b0}}; // R13
      rd_ptr <= {FIFO_AW{1'b0}}; // R13
      count <= {(FIFO_AW+1){1'b0}}; // R13
    end
    else if (lane_clear)
    begin
      wr_ptr <= {FIFO_AW{1'b0}};
      rd_ptr <= {FIFO_AW{1'b0}};
      count <= {(FIFO_AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1; // R12
      if (push & ~pop)
        count <= count + 1'b1;
      else if (pop & ~push)
        count <= count - 1'b1;
    end
  end

  // Overflow: a lost word sets it, set beats a clear in the same cycle
  always @(posedge clk)
  begin
    if (sys_rst)
      overflow <= 1'b0;
    else if (fifo_en & word_done & fifo_full)
      overflow <= 1'b1;
    else if (ovf_clear)
      overflow <= 1'b0;
  end

  // Word to the core
  always @(posedge clk or posedge lane_reset)
  begin
    if (lane_reset)
    begin
      highspeed_rx_word <= `MRD_ZERO_WORD; // R13
      word_valid <= 1'b0;
    end
    else if (lane_clear)
    begin
      highspeed_rx_word <= `MRD_ZERO_WORD;
      word_valid <= 1'b0;
    end
    else if (fifo_en)
    begin
      word_valid <= pop;
      if (pop)
        highspeed_rx_word <= mem[rd_ptr]; // R10 R12
    end
    else
    begin
      word_valid <= word_done;
      if (word_done)
        highspeed_rx_word <= next_word; // R10
    end
  end

endmodule // mrd_lane
`default_nettype wire

// >>> verif/mrd_lane_assertions.sv
// Port checker for the receive lane, bound into mrd_lane.
// Assumes the single clk domain with synchronous sys_rst.
`timescale 1ns/10ps
`default_nettype none
module mrd_lane_chk (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic pad_pos_in, // Pad level
  input wire logic clk_pad_in, // Serial clock pad
  input wire logic forwarded_serial_clock, // Synced serial clock
  input wire logic pad_pos_oe, // Drive enable
  input wire logic pad_neg_out, // Drive value
  input wire logic lowpower_pos_out_enable, // Core enable
  input wire logic lowpower_neg_out_data, // Core data
  input wire logic lowpower_pos_in_data, // Level to core
  input wire logic highspeed_termination_enable, // Request
  input wire logic termination_on, // Switch
  input wire logic forwarded_parallel_clock, // Serial/8
  input wire logic divided_core_clock, // Serial/4
  input wire logic [7:0] highspeed_rx_word, // Word
  input wire logic word_valid, // Word pulse
  input wire logic fifo_empty, // Empty
  input wire logic fifo_read_enable, // Pop
  input wire logic lane_reset // Lane reset
);
  logic [1:0] up;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Pad pipelines hold reset values until three clean edges
  always @(posedge clk)
  begin
    if (sys_rst)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  end
  property p_pos_oe; up != 2'h0 |-> pad_pos_oe == $past(lowpower_pos_out_enable); endproperty
  a_pos_oe: assert property (p_pos_oe) else $error("pos enable not copied");
  property p_neg_out; up != 2'h0 |-> pad_neg_out == $past(lowpower_neg_out_data); endproperty
  a_neg_out: assert property (p_neg_out) else $error("neg data not copied");
  property p_lp_in; up == 2'h3 |-> lowpower_pos_in_data == $past(pad_pos_in, 3); endproperty
  a_lp_in: assert property (p_lp_in) else $error("pos level not passed");
  property p_term; termination_on |-> $past(highspeed_termination_enable); endproperty
  a_term: assert property (p_term) else $error("termination without request");
  property p_pop; fifo_read_enable && !fifo_empty && !lane_reset |=> word_valid; endproperty
  a_pop: assert property (p_pop) else $error("pop gave no word");
  property p_lrst; lane_reset |=> fifo_empty && !word_valid && highspeed_rx_word == 8'h00; endproperty
  a_lrst: assert property (p_lrst) else $error("lane reset left state");
  property p_ldiv; lane_reset |=> !divided_core_clock && !forwarded_parallel_clock; endproperty
  a_ldiv: assert property (p_ldiv) else $error("lane reset left dividers");
  property p_div;
    $changed(forwarded_parallel_clock) && !lane_reset && !$past(lane_reset) |-> $changed(divided_core_clock);
  endproperty
  a_div: assert property (p_div) else $error("dividers out of step");
  property p_fwd;
    up == 2'h3 && !lane_reset && !$past(lane_reset) |-> forwarded_serial_clock == $past(clk_pad_in, 3);
  endproperty
  a_fwd: assert property (p_fwd) else $error("serial clock not forwarded");
endmodule // mrd_lane_chk
bind mrd_lane mrd_lane_chk i_chk (.clk, .sys_rst, .pad_pos_in, .clk_pad_in, .forwarded_serial_clock,
  .pad_pos_oe, .pad_neg_out, .lowpower_pos_out_enable,
  .lowpower_neg_out_data, .lowpower_pos_in_data, .highspeed_termination_enable, .termination_on,
  .forwarded_parallel_clock, .divided_core_clock, .highspeed_rx_word, .word_valid, .fifo_empty,
  .fifo_read_enable, .lane_reset);
`default_nettype wire

// >>> verif/mrd_tx_model.sv
// Serial transmitter model driving the clock lane and one data lane.
// Assumes the bench clk; the serial clock stands low between frames.
`timescale 1ns/10ps
`default_nettype none
module mrd_tx_model (
  input wire logic clk, // Bench clock
  output logic clk_pad_in, // Serial clock pad
  output logic pad_pos_in, // Positive pad
  output logic pad_neg_in // Negative pad
);
  initial
  begin
    clk_pad_in = 1'b0;
    pad_pos_in = 1'b0;
    pad_neg_in = 1'b1;
  end
  // Four clk high and five low per bit, else the sampled clock misses edges
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      pad_pos_in <= b[i];
      pad_neg_in <= ~b[i];
      repeat (4) @(posedge clk);
      clk_pad_in <= 1'b1;
      repeat (4) @(posedge clk);
      clk_pad_in <= 1'b0;
    end
    @(posedge clk);
    pad_pos_in <= ~b[7];
    pad_neg_in <= b[7];
  endtask
  task automatic drive_lp(input logic p, input logic n);
    @(posedge clk);
    pad_pos_in <= p;
    pad_neg_in <= n;
  endtask
endmodule // mrd_tx_model
`default_nettype wire

// >>> verif/mrd_lane_tb.sv
// Self-checking bench for the receive lane and its transmitter model.
// Assumes 25 MHz clk and one wait cycle per register access.
`timescale 1ns/10ps
`default_nettype none
module mrd_lane_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic clk_pad_in, pad_pos_in, pad_neg_in, pad_pos_out, pad_pos_oe, pad_neg_out, pad_neg_oe;
  logic lowpower_pos_out_enable = 1'b0, lowpower_pos_out_data = 1'b0;
  logic lowpower_neg_out_enable = 1'b0, lowpower_neg_out_data = 1'b0;
  logic lowpower_pos_in_data, lowpower_neg_in_data, termination_on, word_valid, fifo_empty;
  logic forwarded_serial_clock, forwarded_parallel_clock, divided_core_clock;
  logic [7:0] highspeed_rx_word;
  logic highspeed_buffer_enable = 1'b1, highspeed_termination_enable = 1'b0, fifo_read_enable = 1'b0;
  logic lane_reset = 1'b0, delay_step_enable = 1'b0, delay_step_direction = 1'b1, delay_counter_clear = 1'b0;
  int n_mismatch = 0, checked = 0, n_core = 0, n_par = 0, n_valid = 0;
  always #20 clk = ~clk;
  always @(divided_core_clock) n_core++;
  always @(posedge word_valid) n_valid++;
  always @(forwarded_parallel_clock) n_par++;
  mrd_lane i_dut (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
    .avs_readdata, .avs_waitrequest, .clk_pad_in, .pad_pos_in, .pad_neg_in, .pad_pos_out, .pad_pos_oe,
    .pad_neg_out, .pad_neg_oe, .lowpower_pos_out_enable, .lowpower_pos_out_data, .lowpower_neg_out_enable,
    .lowpower_neg_out_data, .lowpower_pos_in_data, .lowpower_neg_in_data, .highspeed_buffer_enable,
    .highspeed_termination_enable, .termination_on, .forwarded_serial_clock, .forwarded_parallel_clock,
    .divided_core_clock, .highspeed_rx_word, .word_valid, .fifo_empty, .fifo_read_enable, .lane_reset,
    .delay_step_enable, .delay_step_direction, .delay_counter_clear);
  mrd_tx_model i_tx (.clk, .clk_pad_in, .pad_pos_in, .pad_neg_in);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_reset;
    chk("empty", 32'h1, 32'(fifo_empty));
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl", 32'h3, rd);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic t_words;
    n_core = 0;
    n_par = 0;
    i_tx.send_byte(8'ha5);
    i_tx.send_byte(8'h3c);
    repeat (4) @(posedge clk);
    chk("core toggles", 32'h8, n_core);
    chk("par toggles", 32'h4, n_par);
    bus(1'b0, 4'h4, 32'h0);
    chk("status", 32'h0002_0000, rd);
    fifo_read_enable <= 1'b1;
    @(posedge clk);
    fifo_read_enable <= 1'b0;
    @(posedge clk);
    chk("valid", 32'h1, 32'(word_valid));
    chk("word", 32'ha5, 32'(highspeed_rx_word));
    bus(1'b0, 4'h8, 32'h0);
    chk("data", 32'h3c, rd);
    chk("empty", 32'h1, 32'(fifo_empty));
  endtask
  task automatic t_refuse;
    highspeed_buffer_enable <= 1'b0;
    i_tx.send_byte(8'hff);
    repeat (4) @(posedge clk);
    chk("buffer off", 32'h1, 32'(fifo_empty));
    highspeed_buffer_enable <= 1'b1;
  endtask
  task automatic t_lp;
    bus(1'b1, 4'h0, 32'h2);
    highspeed_termination_enable <= 1'b1;
    lowpower_pos_out_enable <= 1'b1;
    lowpower_pos_out_data <= 1'b1;
    lowpower_neg_out_data <= 1'b1;
    i_tx.drive_lp(1'b1, 1'b0);
    repeat (5) @(posedge clk);
    chk("term lp", 32'h0, 32'(termination_on));
    chk("pos drive", 32'h3, 32'({pad_pos_oe, pad_pos_out}));
    chk("neg drive", 32'h1, 32'({pad_neg_oe, pad_neg_out}));
    chk("lp in", 32'h1, 32'({lowpower_neg_in_data, lowpower_pos_in_data}));
    i_tx.drive_lp(1'b0, 1'b1);
    repeat (5) @(posedge clk);
    bus(1'b0, 4'hc, 32'h0);
    chk("lpin", 32'h2, rd);
    bus(1'b1, 4'h0, 32'h3);
    @(posedge clk);
    chk("term hs", 32'h1, 32'(termination_on));
    highspeed_termination_enable <= 1'b0;
  endtask
  task automatic t_delay;
    delay_step_enable <= 1'b1;
    i_tx.send_byte(8'h81);
    repeat (4) @(posedge clk);
    delay_step_enable <= 1'b0;
    bus(1'b0, 4'h4, 32'h0);
    chk("tap up", 32'h0001_0100, rd);
    delay_counter_clear <= 1'b1;
    @(posedge clk);
    delay_counter_clear <= 1'b0;
    bus(1'b0, 4'h4, 32'h0);
    chk("tap clear", 32'h0001_0000, rd);
    lane_reset <= 1'b1;
    @(posedge clk);
    lane_reset <= 1'b0;
    @(posedge clk);
    chk("lane reset", 32'h1, 32'(fifo_empty));
  endtask
  task automatic t_direct;
    bus(1'b1, 4'h0, 32'h1);
    n_valid = 0;
    i_tx.send_byte(8'h5a);
    repeat (4) @(posedge clk);
    chk("direct valid", 32'h1, n_valid);
    chk("direct word", 32'h5a, 32'(highspeed_rx_word));
    chk("direct empty", 32'h1, 32'(fifo_empty));
    bus(1'b0, 4'h8, 32'h0);
    chk("direct data", 32'h5a, rd);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_words;
    t_refuse;
    t_lp;
    t_delay;
    t_direct;
    results;
  end
  // Tests need about 430 cycles; the 5000-cycle limit allows over ten times that
  initial
  begin
    #200000;
    n_mismatch++;
    results;
  end
endmodule // mrd_lane_tb
`default_nettype wire
